// *** src/cmrg_map.vh ***
// Purpose: Offsets, field positions, reset values and timing constants of the clock monitor block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Included by the top module and the testbench
`ifndef CMRG_MAP_VH
`define CMRG_MAP_VH

`define CMRG_CTRL_OFS       12'h000
`define CMRG_STAT_OFS       12'h004

`define CMRG_CTRL_EXT_ON    0
`define CMRG_CTRL_INT_ON    1
`define CMRG_CTRL_SLOW      2
`define CMRG_CTRL_MON_ON    3
`define CMRG_CTRL_STOP      4
`define CMRG_CTRL_RST       32'h00000000

`define CMRG_STAT_EXT_STB   0
`define CMRG_STAT_INT_STB   1
`define CMRG_STAT_INT_DEAD  2
`define CMRG_STAT_EXT_DEAD  3
`define CMRG_STAT_MON_ON    4
`define CMRG_STAT_OSC_EN    5
`define CMRG_STAT_LOW_GAIN  6

`define CMRG_SHORT_DIV      4
`define CMRG_LONG_DIV       4096
`define CMRG_LONG_EXT_TAP   128
`define CMRG_LONG_INT_TAP   16
`define CMRG_MISS_LIMIT     2
`define CMRG_MEAS_OK_NEED   2

`endif

// *** src/cmrg_top.v ***
// Purpose: Clock monitor reference generator, activity detectors and stable flags
// Assumes: Base and external clocks arrive as asynchronous levels sampled on I_REF_CLK
// Notes:   Edge detection is done on synchronised copies; the oscillator pins are modelled as controls
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cmrg_map.vh"

module cmrg_top #(
  parameter LONG_DIV = `CMRG_LONG_DIV                 // Stabilization divider length
) (
  input  wire        I_REF_CLK,                       // 125 MHz system clock
  input  wire        I_RST,                           // Synchronous reset, active high
  input  wire        I_BASE_CLOCK,                    // Base clock level, asynchronous
  input  wire        I_OSC_IN_PIN,                    // Oscillator input pin level
  input  wire        I_FREQ_IN_WINDOW,                // Frequency comparator within 5 percent
  input  wire        I_FREQ_MEAS_DONE,                // Frequency measurement complete pulse
  input  wire [11:0] I_PADDR,                         // APB address
  input  wire        I_PSEL,                          // APB select
  input  wire        I_PENABLE,                       // APB enable
  input  wire        I_PWRITE,                        // APB direction
  input  wire [31:0] I_PWDATA,                        // APB write data
  output reg  [31:0] O_PRDATA,                        // APB read data
  output reg         O_PREADY,                        // APB ready
  output reg         O_PSLVERR,                       // APB error
  output reg         O_OSC_AMP_EN,                    // Oscillator amplifier enable
  output reg         O_OSC_LOW_GAIN,                  // Reduced amplifier gain
  output reg         O_EXTERNAL_CLOCK,                // Buffered external clock level
  output reg         O_EXT_REFERENCE,                 // External reference level
  output reg         O_INT_REFERENCE,                 // Internal reference level
  output reg         O_STABILIZATION_CLOCK,           // Stabilization clock level
  output reg         O_INT_DEAD_FLAG,                 // Internal clock inactive
  output reg         O_EXT_DEAD_FLAG,                 // External clock inactive
  output reg         O_INT_STABLE_FLAG,               // Internal clock stable
  output reg         O_EXT_STABLE_FLAG,               // External clock stable
  output reg         O_MONITOR_FAIL                   // Monitor detected a dead clock
);

  // Divider taps follow from the divide ratios; a shorter LONG_DIV shortens the stabilization wait
  localparam integer LONG_LAST = LONG_DIV - 1;
  localparam integer STB_TAP   = $clog2(LONG_DIV) - 1;
  localparam integer EXT_TAP   = $clog2(`CMRG_LONG_EXT_TAP) - 1;
  localparam integer INT_TAP   = $clog2(`CMRG_LONG_INT_TAP) - 1;

  reg [1:0]  base_sync_r;
  reg [1:0]  osc_sync_r;
  reg [1:0]  win_sync_r;
  reg        base_d_r;
  reg        ext_d_r;
  reg        ext_gen_on_r;
  reg        int_gen_on_r;
  reg        slow_crystal_select_r;
  reg        monitor_on_r;
  reg        stop_mode_r;
  reg [1:0]  base_div_r;
  reg [1:0]  ext_div_r;
  reg [11:0] long_div_r;
  reg        int_ref_d_r;
  reg        ext_ref_d_r;
  reg        int_edge_seen_r;
  reg        ext_edge_seen_r;
  reg [1:0]  int_miss_r;
  reg [1:0]  ext_miss_r;
  reg [1:0]  meas_ok_r;
  reg        stb_d_r;

  wire       base_lvl;
  wire       ext_lvl;
  wire       base_fall;
  wire       ext_fall;
  wire       ext_path_en;
  wire       long_on_ext;
  reg        long_tick;
  reg  [11:0] long_div_nxt;
  reg        ext_ref_nxt;
  reg        int_ref_nxt;
  reg        stb_nxt;
  wire       wr_en;
  wire       rd_en;
  wire       addr_ok;
  wire [31:0] ctrl_word;
  wire [31:0] stat_word;

  assign ext_path_en = ext_gen_on_r & ~stop_mode_r;
  assign base_lvl    = base_sync_r[1] & int_gen_on_r;
  assign ext_lvl     = osc_sync_r[1] & ext_path_en;
  assign base_fall   = base_d_r & ~base_lvl;
  assign ext_fall    = ext_d_r & ~ext_lvl;

  // Long divider counts the external clock until stable, and again in fast-crystal mode
  assign long_on_ext = ~O_EXT_STABLE_FLAG | ~slow_crystal_select_r;

  // Long divider stepping, stabilization clock and reference selection
  always @*
  begin
    if (long_on_ext)
    begin
      long_tick = ext_fall & (ext_div_r == 2'h3);
    end
    else
    begin
      long_tick = base_fall & (base_div_r == 2'h3);
    end
    if ({20'h00000, long_div_r} == LONG_LAST)
    begin
      long_div_nxt = 12'h000;
    end
    else
    begin
      long_div_nxt = long_div_r + 12'h001;
    end
    // Top bit of the divider falls only after a full period
    stb_nxt = long_div_r[STB_TAP];
    if (O_EXT_STABLE_FLAG & ~slow_crystal_select_r)
    begin
      ext_ref_nxt = long_div_r[EXT_TAP];
    end
    else
    begin
      ext_ref_nxt = ext_div_r[1];
    end
    if (O_EXT_STABLE_FLAG & slow_crystal_select_r)
    begin
      int_ref_nxt = long_div_r[INT_TAP];
    end
    else
    begin
      int_ref_nxt = base_div_r[1];
    end
  end

  // Writes land on the edge at which the master samples ready high
  assign wr_en   = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign rd_en   = I_PSEL & I_PENABLE & ~I_PWRITE & ~O_PREADY;
  assign addr_ok = (I_PADDR == `CMRG_CTRL_OFS) | (I_PADDR == `CMRG_STAT_OFS);

  assign ctrl_word = {27'h0000000, stop_mode_r, monitor_on_r, slow_crystal_select_r,
                      int_gen_on_r, ext_gen_on_r};
  assign stat_word = {25'h0000000, O_OSC_LOW_GAIN, O_OSC_AMP_EN, monitor_on_r, O_EXT_DEAD_FLAG,
                      O_INT_DEAD_FLAG, O_INT_STABLE_FLAG, O_EXT_STABLE_FLAG};

  // Two-flop synchronisers for asynchronous clock and comparator levels
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      base_sync_r <= 2'h0;
      osc_sync_r  <= 2'h0;
      win_sync_r  <= 2'h0;
    end
    else
    begin
      base_sync_r <= {base_sync_r[0], I_BASE_CLOCK};
      osc_sync_r  <= {osc_sync_r[0], I_OSC_IN_PIN};
      win_sync_r  <= {win_sync_r[0], I_FREQ_IN_WINDOW};
    end
  end

  // APB slave: one wait state, error on unmapped address
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      O_PREADY              <= 1'b0;
      O_PSLVERR             <= 1'b0;
      O_PRDATA              <= 32'h00000000;
      ext_gen_on_r          <= 1'b0;
      int_gen_on_r          <= 1'b0;
      slow_crystal_select_r <= 1'b0;
      monitor_on_r          <= 1'b0;
      stop_mode_r           <= 1'b0;
    end
    else
    begin
      O_PREADY  <= I_PSEL & I_PENABLE & ~O_PREADY;
      O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & ~addr_ok;
      if (rd_en)
        O_PRDATA <= (I_PADDR == `CMRG_CTRL_OFS) ? ctrl_word :
                    (I_PADDR == `CMRG_STAT_OFS) ? stat_word : 32'h00000000;
      if (wr_en & (I_PADDR == `CMRG_CTRL_OFS))
      begin
        ext_gen_on_r          <= I_PWDATA[`CMRG_CTRL_EXT_ON];
        int_gen_on_r          <= I_PWDATA[`CMRG_CTRL_INT_ON];
        slow_crystal_select_r <= I_PWDATA[`CMRG_CTRL_SLOW];
        stop_mode_r           <= I_PWDATA[`CMRG_CTRL_STOP];
        if (!I_PWDATA[`CMRG_CTRL_MON_ON])
          monitor_on_r <= 1'b0;
        else if (I_PWDATA[`CMRG_CTRL_EXT_ON] & I_PWDATA[`CMRG_CTRL_INT_ON] &
                 ext_gen_on_r & int_gen_on_r & O_EXT_STABLE_FLAG & O_INT_STABLE_FLAG)
          monitor_on_r <= 1'b1;
        // Otherwise keeps its value, so losing stability never clears it
      end
    end
  end

  // Dividers, clock edge history and stabilization clock
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      base_d_r   <= 1'b0;
      ext_d_r    <= 1'b0;
      base_div_r <= 2'h0;
      ext_div_r  <= 2'h0;
      long_div_r <= 12'h000;
      stb_d_r    <= 1'b0;
    end
    else
    begin
      base_d_r <= base_lvl;
      ext_d_r  <= ext_lvl;
      stb_d_r  <= stb_nxt;
      if (base_fall)
        base_div_r <= base_div_r + 2'h1;
      if (ext_fall)
        ext_div_r <= ext_div_r + 2'h1;
      if (!ext_gen_on_r)
        long_div_r <= 12'h000;
      else if (long_tick)
        long_div_r <= long_div_nxt;
    end
  end

  // Activity detectors: count reference low phases without a falling edge
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      int_ref_d_r     <= 1'b0;
      ext_ref_d_r     <= 1'b0;
      int_edge_seen_r <= 1'b0;
      ext_edge_seen_r <= 1'b0;
      int_miss_r      <= 2'h0;
      ext_miss_r      <= 2'h0;
      O_INT_DEAD_FLAG <= 1'b0;
      O_EXT_DEAD_FLAG <= 1'b0;
    end
    else
    begin
      ext_ref_d_r <= ext_ref_nxt;
      int_ref_d_r <= int_ref_nxt;
      if (!ext_ref_nxt & base_fall)
      begin
        int_edge_seen_r <= 1'b1;
        int_miss_r      <= 2'h0;
        O_INT_DEAD_FLAG <= 1'b0;
      end
      else if (ext_ref_nxt & ~ext_ref_d_r)
      begin
        int_edge_seen_r <= 1'b0;
        if (!int_edge_seen_r)
        begin
          if (int_miss_r == `CMRG_MISS_LIMIT - 1)
            O_INT_DEAD_FLAG <= 1'b1;
          else
            int_miss_r <= int_miss_r + 2'h1;
        end
      end
      if (!int_ref_nxt & ext_fall)
      begin
        ext_edge_seen_r <= 1'b1;
        ext_miss_r      <= 2'h0;
        O_EXT_DEAD_FLAG <= 1'b0;
      end
      else if (int_ref_nxt & ~int_ref_d_r)
      begin
        ext_edge_seen_r <= 1'b0;
        if (!ext_edge_seen_r)
        begin
          if (ext_miss_r == `CMRG_MISS_LIMIT - 1)
            O_EXT_DEAD_FLAG <= 1'b1;
          else
            ext_miss_r <= ext_miss_r + 2'h1;
        end
      end
    end
  end

  // Stable flags and output registers
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      meas_ok_r             <= 2'h0;
      O_INT_STABLE_FLAG     <= 1'b0;
      O_EXT_STABLE_FLAG     <= 1'b0;
      O_OSC_AMP_EN          <= 1'b0;
      O_OSC_LOW_GAIN        <= 1'b0;
      O_EXTERNAL_CLOCK      <= 1'b0;
      O_EXT_REFERENCE       <= 1'b0;
      O_INT_REFERENCE       <= 1'b0;
      O_STABILIZATION_CLOCK <= 1'b0;
      O_MONITOR_FAIL        <= 1'b0;
    end
    else
    begin
      if (!ext_gen_on_r | O_EXT_DEAD_FLAG)
        O_EXT_STABLE_FLAG <= 1'b0;
      else if (stb_d_r & ~stb_nxt)
        O_EXT_STABLE_FLAG <= 1'b1;
      if (!int_gen_on_r | O_INT_DEAD_FLAG | (I_FREQ_MEAS_DONE & ~win_sync_r[1]))
      begin
        meas_ok_r         <= 2'h0;
        O_INT_STABLE_FLAG <= 1'b0;
      end
      else if (I_FREQ_MEAS_DONE)
      begin
        if (meas_ok_r == `CMRG_MEAS_OK_NEED - 1)
          O_INT_STABLE_FLAG <= 1'b1;
        else
          meas_ok_r <= meas_ok_r + 2'h1;
      end
      O_OSC_AMP_EN          <= ext_path_en;
      O_OSC_LOW_GAIN        <= slow_crystal_select_r;
      O_EXTERNAL_CLOCK      <= ext_lvl;
      O_EXT_REFERENCE       <= ext_ref_nxt;
      O_INT_REFERENCE       <= int_ref_nxt;
      O_STABILIZATION_CLOCK <= stb_nxt;
      O_MONITOR_FAIL        <= monitor_on_r & (O_INT_DEAD_FLAG | O_EXT_DEAD_FLAG);
    end
  end

endmodule // cmrg_top

// *** tb/cmrg_monitor.sv ***
// Purpose: Port-level assertions for the clock monitor block
// Assumes: Control bits are mirrored from completed APB writes
// Notes:   Attached to cmrg_top by bind
`timescale 1ns/1ps
module cmrg_monitor (
  input wire        I_REF_CLK,             // Clock
  input wire        I_RST,                 // Reset
  input wire [11:0] I_PADDR,               // APB address
  input wire        I_PSEL,                // APB select
  input wire        I_PENABLE,             // APB enable
  input wire        I_PWRITE,              // APB direction
  input wire [31:0] I_PWDATA,              // APB write data
  input wire        I_FREQ_MEAS_DONE,      // Measurement pulse
  input wire        O_PREADY,              // APB ready
  input wire        O_PSLVERR,             // APB error
  input wire        O_OSC_AMP_EN,          // Amplifier on
  input wire        O_OSC_LOW_GAIN,        // Low gain
  input wire        O_EXTERNAL_CLOCK,      // External clock
  input wire        O_STABILIZATION_CLOCK, // Stabilization clock
  input wire        O_INT_DEAD_FLAG,       // Internal dead
  input wire        O_EXT_DEAD_FLAG,       // External dead
  input wire        O_INT_STABLE_FLAG,     // Internal stable
  input wire        O_EXT_STABLE_FLAG,     // External stable
  input wire        O_MONITOR_FAIL         // Monitor fail
);
  reg  [4:0] ctl_r;
  wire       run_w = ctl_r[0] & ~ctl_r[4];
  always @(posedge I_REF_CLK)
  begin
    if (I_RST)
      ctl_r <= 5'h00;
    else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h000)
      ctl_r <= I_PWDATA[4:0];
  end
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  property p_wait; I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY; endproperty
  a_wait: assert property (p_wait) else $error("ready missing after wait state");
  property p_err; O_PSLVERR |-> O_PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_amp; $stable(ctl_r)[*3] |-> O_OSC_AMP_EN == run_w; endproperty
  a_amp: assert property (p_amp) else $error("amplifier enable wrong");
  property p_gain; $stable(ctl_r)[*3] |-> O_OSC_LOW_GAIN == ctl_r[2]; endproperty
  a_gain: assert property (p_gain) else $error("gain select wrong");
  property p_path; (!run_w)[*6] |-> !O_EXTERNAL_CLOCK; endproperty
  a_path: assert property (p_path) else $error("clock path open while off");
  property p_ext_off; ($stable(ctl_r) && !ctl_r[0])[*4] |-> !O_EXT_STABLE_FLAG && !O_STABILIZATION_CLOCK; endproperty
  a_ext_off: assert property (p_ext_off) else $error("external side active while off");
  property p_int_off; ($stable(ctl_r) && !ctl_r[1])[*4] |-> !O_INT_STABLE_FLAG; endproperty
  a_int_off: assert property (p_int_off) else $error("internal stable while off");
  property p_int_dead; O_INT_DEAD_FLAG[*2] |-> !O_INT_STABLE_FLAG; endproperty
  a_int_dead: assert property (p_int_dead) else $error("internal stable while dead");
  property p_ext_dead; $rose(O_EXT_DEAD_FLAG) |-> ##[0:2] !O_EXT_STABLE_FLAG; endproperty
  a_ext_dead: assert property (p_ext_dead) else $error("external stable kept while dead");
  property p_ext_set; $rose(O_EXT_STABLE_FLAG) |-> $past(O_STABILIZATION_CLOCK) || $past(O_STABILIZATION_CLOCK, 2);
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external stable without divider fall");
  property p_int_set; $rose(O_INT_STABLE_FLAG) |-> $past(I_FREQ_MEAS_DONE) || $past(I_FREQ_MEAS_DONE, 2); endproperty
  a_int_set: assert property (p_int_set) else $error("internal stable without measurement");
  property p_fail; O_MONITOR_FAIL |-> O_INT_DEAD_FLAG || O_EXT_DEAD_FLAG || $past(O_INT_DEAD_FLAG || O_EXT_DEAD_FLAG);
  endproperty
  a_fail: assert property (p_fail) else $error("fail without dead clock");
  property p_mon; O_MONITOR_FAIL |-> ctl_r[3] || $past(ctl_r[3]); endproperty
  a_mon: assert property (p_mon) else $error("fail while monitor never enabled");
endmodule // cmrg_monitor

bind cmrg_top cmrg_monitor u_cmrg_monitor (.I_REF_CLK, .I_RST, .I_PADDR, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PWDATA,
  .I_FREQ_MEAS_DONE, .O_PREADY, .O_PSLVERR, .O_OSC_AMP_EN, .O_OSC_LOW_GAIN, .O_EXTERNAL_CLOCK,
  .O_STABILIZATION_CLOCK, .O_INT_DEAD_FLAG, .O_EXT_DEAD_FLAG, .O_INT_STABLE_FLAG, .O_EXT_STABLE_FLAG, .O_MONITOR_FAIL);

// *** tb/cmrg_osc_model.sv ***
// Purpose: External clock source at the oscillator input pin
// Assumes: Toggles every HALF cycles while the amplifier is on and the source is alive, and every cycle while the amplifier is off
// Notes:   An undriven pin shows a level that changes every cycle
`timescale 1ns/1ps
module cmrg_osc_model #(
  parameter HALF = 4        // Half period in system clocks
) (
  input  wire i_clk,        // System clock
  input  wire i_amp_en,     // Amplifier enable
  input  wire i_run,        // Source alive; low freezes the pin while the amplifier is on
  output reg  o_pin         // Oscillator input pin
);
  integer cnt_r;
  initial
  begin
    o_pin = 1'b0;
    cnt_r = 0;
  end
  always @(posedge i_clk)
  begin
    if (!i_amp_en)
      o_pin <= ~o_pin;
    else if (i_run)
    begin
      cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
      if (cnt_r == HALF - 1)
        o_pin <= ~o_pin;
    end
  end
endmodule // cmrg_osc_model

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the clock monitor block
// Assumes: Flags are judged by status reads and bounded waits on flag outputs
// Notes:   Each transfer queues its expected answer; a watcher compares
`timescale 1ns/1ps
`include "cmrg_map.vh"
module testbench;
  reg         clk, rst, base, in_win, meas, psel, pen, pwr, base_run, meas_run, osc_run;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, seed;
  reg  [7:0]  ctr;
  reg  [64:0] q[$];
  reg  [64:0] qe;
  wire [31:0] prdata;
  wire        pready, slverr, osc, amp, estb, istb, edead, idead, ext_reference, int_reference, mfail;
  integer     fails, checks, i;

  // Short stabilization divider keeps the run inside the cycle budget
  cmrg_top #(.LONG_DIV(256)) u_cmrg_top (.I_REF_CLK(clk), .I_RST(rst), .I_BASE_CLOCK(base), .I_OSC_IN_PIN(osc),
    .I_FREQ_IN_WINDOW(in_win), .I_FREQ_MEAS_DONE(meas), .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(slverr),
    .O_OSC_AMP_EN(amp), .O_OSC_LOW_GAIN(), .O_EXTERNAL_CLOCK(), .O_EXT_REFERENCE(ext_reference), .O_INT_REFERENCE(int_reference),
    .O_STABILIZATION_CLOCK(), .O_INT_DEAD_FLAG(idead), .O_EXT_DEAD_FLAG(edead), .O_INT_STABLE_FLAG(istb),
    .O_EXT_STABLE_FLAG(estb), .O_MONITOR_FAIL(mfail));
  cmrg_osc_model #(.HALF(4)) u_cmrg_osc_model (.i_clk(clk), .i_amp_en(amp), .i_run(osc_run), .o_pin(osc));

  always #4 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic flag(input integer s);
    return s == 0 ? estb : s == 1 ? istb : s == 2 ? edead : s == 3 ? idead : s == 4 ? mfail : s == 5 ? ext_reference : int_reference;
  endfunction

  // Counts clock edges from one rising edge of a reference to the next
  task automatic period(input integer s, input integer exp);
    integer n;
    for (n = 0; n < 10000 && flag(s) !== 1'b0; n = n + 1)
      @(posedge clk);
    for (n = 0; n < 10000 && flag(s) !== 1'b1; n = n + 1)
      @(posedge clk);
    for (n = 0; n < 10000 && flag(s) !== 1'b0; n = n + 1)
      @(posedge clk);
    for (; n < 10000 && flag(s) !== 1'b1; n = n + 1)
      @(posedge clk);
    cmp({1'b0, n[31:0]}, {1'b0, exp[31:0]});
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reads expect d under mask m; writes expect only the error bit
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er,
                     input logic [31:0] m);
    integer n;
    seed = xs(seed);
    q.push_back({er, w ? 32'h0 : m, w ? 32'h0 : d});
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= w ? {seed[31:5], d[4:0]} : seed;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n = n + 1)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (pready !== 1'b1)
    begin
      fails = fails + 1;
      conclude;
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_for(input integer s, input logic v, input integer lim);
    integer n;
    for (n = 0; n < lim && flag(s) !== v; n = n + 1)
      @(posedge clk);
    cmp({32'h0, flag(s)}, {32'h0, v});
    if (flag(s) !== v)
      conclude;
  endtask

  always @(posedge clk)
  begin
    ctr <= ctr + 8'h01;
    if (base_run && ctr[1:0] == 2'b11)
      base <= ~base;
    meas <= meas_run && ctr[5:0] == 6'h3f;
    if (psel && pen && pready === 1'b1)
    begin
      qe = q.pop_front();
      cmp({slverr, prdata & qe[63:32]}, {qe[64], qe[31:0]});
    end
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {base, in_win, meas, psel, pen, pwr, base_run, meas_run, osc_run} = 9'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    ctr = 8'h00;
    seed = 32'hf296;
    fails = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(0, `CMRG_STAT_OFS, 32'h0, 0, 32'hffffffff);
    apb(0, `CMRG_CTRL_OFS, `CMRG_CTRL_RST, 0, 32'hffffffff);
    apb(0, 12'h008, 32'h0, 1, 32'hffffffff);
    apb(1, 12'h00c, 32'h1f, 1, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      // External on with every mix of slow and stop
      apb(1, `CMRG_CTRL_OFS, {27'h0, i[1], 1'b0, i[0], 2'b01}, 0, 32'h0);
      apb(0, `CMRG_STAT_OFS, {25'h0, i[0], !i[1], 5'h0}, 0, 32'h60);
    end
    apb(1, `CMRG_CTRL_OFS, 32'h0b, 0, 32'h0);
    apb(0, `CMRG_STAT_OFS, 32'h0, 0, 32'h10);
    {base_run, meas_run, osc_run, in_win} <= 4'hf;
    wait_for(0, 1, 40000);
    wait_for(1, 1, 2000);
    apb(0, `CMRG_STAT_OFS, 32'h03, 0, 32'h0f);
    // Source clocks have a period of 8 system clocks
    period(5, `CMRG_LONG_EXT_TAP * `CMRG_SHORT_DIV * 8);
    period(6, `CMRG_SHORT_DIV * 8);
    apb(1, `CMRG_CTRL_OFS, 32'h07, 0, 32'h0);
    period(6, `CMRG_LONG_INT_TAP * `CMRG_SHORT_DIV * 8);
    period(5, `CMRG_SHORT_DIV * 8);
    apb(1, `CMRG_CTRL_OFS, 32'h0b, 0, 32'h0);
    apb(0, `CMRG_STAT_OFS, 32'h13, 0, 32'h1f);
    osc_run <= 1'b0;
    wait_for(2, 1, 2000);
    wait_for(4, 1, 20);
    apb(0, `CMRG_STAT_OFS, 32'h18, 0, 32'h19);
    osc_run <= 1'b1;
    wait_for(2, 0, 2000);
    wait_for(4, 0, 20);
    base_run <= 1'b0;
    wait_for(3, 1, 2000);
    apb(0, `CMRG_STAT_OFS, 32'h14, 0, 32'h16);
    base_run <= 1'b1;
    wait_for(3, 0, 2000);
    wait_for(1, 1, 2000);
    in_win <= 1'b0;
    wait_for(1, 0, 2000);
    apb(1, `CMRG_CTRL_OFS, 32'h0, 0, 32'h0);
    apb(0, `CMRG_STAT_OFS, 32'h0, 0, 32'h13);
    conclude;
  end
endmodule // testbench
